// file: fcu_pkg.sv
package fcu_pkg;

    // Word geometry
    localparam int MAN_W       = 32;
    localparam int EXP_W       = 8;
    localparam int WEXP_W      = 10;               // Widened exponent for range checks
    localparam int LEAD_W      = 6;                // Holds a lead count of 1..32

    // Exponent codes
    localparam logic [7:0] EXP_ZERO = 8'h80;       // -128 marks a floating zero
    localparam logic [7:0] EXP_MAX  = 8'h7F;
    localparam int         EXP_MIN  = -127;        // Smallest exponent of a nonzero value

    // Integer conversion limits
    localparam int          FIX_EXP_MAX  = 30;
    localparam int          FIX_SHIFT    = 31;     // Right shift is this minus the exponent
    localparam int          FIX_SH_CLAMP = 33;     // Any shift beyond this only sign-fills
    localparam logic [31:0] INT_MAX      = 32'h7FFF_FFFF;
    localparam logic [31:0] INT_MIN      = 32'h8000_0000;
    localparam int          FLOAT_EXP    = 31;     // Integer seen as mantissa times 2^31

    // Rounding to single precision
    localparam int          RND_OFFS  = 24;
    localparam int          RND_POS   = FIX_SHIFT - RND_OFFS;   // Bit weight 2^(exp-24)
    localparam logic [31:0] SGL_MASK  = 32'hFFFF_FF00;          // Keeps 23 fraction bits
    localparam logic [31:0] SGL_POS_MAX = 32'h7FFF_FF00;
    localparam logic [31:0] EXT_NEG_MAX = 32'h8000_0000;

    // Operation codes
    typedef enum logic [3:0] {
        FCU_OP_NORM  = 4'b0001,
        FCU_OP_RND   = 4'b0010,
        FCU_OP_FIX   = 4'b0100,
        FCU_OP_FLOAT = 4'b1000
    } fcu_op_type;

    // Extended-precision word: exponent above mantissa
    typedef struct packed {
        logic [7:0]  exp;
        logic [31:0] man;
    } fcu_ext_type;

    typedef struct packed {
        logic        valid;
        fcu_op_type  op;
        fcu_ext_type opnd;
    } fcu_req_type;

    typedef struct packed {
        logic        valid;
        fcu_ext_type value;
        logic        ovf;
        logic        unf;
        logic        zero;
        logic        neg;
    } fcu_rsp_type;

    localparam fcu_rsp_type RSP_RESET = '0;

endpackage

// file: fcu_lead_count.sv
`timescale 1ns/1ps

// Counts leading bits equal to the top bit, the top bit included
module fcu_lead_count
    import fcu_pkg::*;
#(
    parameter int W  = MAN_W,
    parameter int CW = LEAD_W
)
(
    // Operand
    input  wire logic [W-1:0]  value,
    // Result
    output logic      [CW-1:0] count
);

    // Refuse widths the counter cannot hold, at elaboration
    if (W < 2 || (1 << CW) <= W)
    begin : g_bad_width
        $error("fcu_lead_count: width parameters out of range");
    end

    // Priority search from just below the sign downward
    always_comb
    begin
        logic found;
        found = 1'b0;
        count = CW'(W);
        for (int i = W - 2; i >= 0; i--)
        begin
            if (!found && value[i] != value[W-1])
            begin
                count = CW'(W - 1 - i);
                found = 1'b1;
            end
        end
    end

endmodule // fcu_lead_count

// file: fcu_unit.sv
`timescale 1ns/1ps

module fcu_unit
    import fcu_pkg::*;
(
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  reset_n,
    // Operation request from decode
    input  wire fcu_req_type req,
    // Registered result toward the register file
    output fcu_rsp_type rsp
);

    // Slices below are written for this geometry; other widths need new wiring
    // and a wider exponent to hold the worst shift without wrapping
    if (MAN_W != 32 || EXP_W != 8 || WEXP_W < EXP_W + 2 || (1 << LEAD_W) <= MAN_W)
    begin : g_bad_geometry
        $error("fcu_unit: package geometry not supported");
    end

    // Result register
    fcu_rsp_type rsp_reg;
    fcu_rsp_type rsp_next;

    // Shared normalizer operands
    logic [MAN_W-1:0]         norm_src_man;
    logic signed [WEXP_W-1:0] norm_src_exp;
    logic [LEAD_W-1:0]        norm_lead;

    // Source selection for the normalizer; FLOAT reuses it with a fixed exponent
    always_comb
    begin
        norm_src_man = req.opnd.man;
        norm_src_exp = WEXP_W'($signed(req.opnd.exp));
        if (req.op == FCU_OP_FLOAT)
            norm_src_exp = WEXP_W'(FLOAT_EXP);
    end

    // Leading sign bit count of the raw mantissa, no implied bit assumed
    fcu_lead_count #(
        .W  (MAN_W),
        .CW (LEAD_W)
    ) u_lead (
        .value (norm_src_man),
        .count (norm_lead)
    );

    // Datapath for all four operations
    always_comb
    begin
        logic [LEAD_W-1:0]        shift_n;
        logic [MAN_W:0]           ext33;
        logic [MAN_W:0]           sh33;
        logic signed [WEXP_W-1:0] exp_w;
        logic signed [MAN_W+1:0]  sum34;
        logic signed [MAN_W:0]    fix33;
        logic signed [MAN_W:0]    fix_sh;
        logic signed [WEXP_W-1:0] fix_amt;
        logic [31:0]              man_w;
        logic                     sgn;
        shift_n  = '0;
        ext33    = '0;
        sh33     = '0;
        exp_w    = '0;
        sum34    = '0;
        fix33    = '0;
        fix_sh   = '0;
        fix_amt  = '0;
        man_w    = '0;
        sgn      = req.opnd.man[MAN_W-1];
        rsp_next = RSP_RESET;
        rsp_next.valid = req.valid;

        unique case (req.op)
            FCU_OP_NORM, FCU_OP_FLOAT:
            begin
                // Full lead count puts the first nonsign bit on the implied position;
                // an all-ones word takes all 32 steps to reach 10.0
                shift_n = norm_lead;
                ext33 = {norm_src_man[MAN_W-1], norm_src_man};
                sh33  = ext33 << shift_n;
                exp_w = norm_src_exp - WEXP_W'(shift_n);
                if (norm_src_man == '0)
                begin
                    // Zero in gives the zero code, never a runaway shift
                    rsp_next.value.exp = EXP_ZERO;
                    rsp_next.value.man = '0;
                    rsp_next.zero      = 1'b1;
                end
                else if (exp_w < WEXP_W'(EXP_MIN))
                begin
                    // Too small to carry: flush to zero
                    rsp_next.value.exp = EXP_ZERO;
                    rsp_next.value.man = '0;
                    rsp_next.unf       = 1'b1;
                    rsp_next.zero      = 1'b1;
                end
                else
                begin
                    // Drop the redundant bit next to the sign
                    rsp_next.value.man = {sh33[MAN_W], sh33[MAN_W-2:0]};
                    rsp_next.value.exp = exp_w[EXP_W-1:0];
                    rsp_next.neg       = sh33[MAN_W];
                end
            end

            FCU_OP_RND:
            begin
                exp_w = WEXP_W'($signed(req.opnd.exp));
                // Two guard bits above the implied bit catch carry out
                sum34 = $signed({sgn, sgn, ~sgn, req.opnd.man[MAN_W-2:0]})
                      + $signed((MAN_W+2)'(1) << RND_POS);
                if (sum34[MAN_W+1] != sum34[MAN_W])
                begin
                    // Magnitude reached two: move right once
                    man_w = {sum34[MAN_W+1], sum34[MAN_W-1:1]};
                    exp_w = exp_w + WEXP_W'(1);
                end
                else if (sum34[MAN_W] == sum34[MAN_W-1])
                begin
                    // Negative value crossed to -1.0: move left once
                    man_w = {sum34[MAN_W], sum34[MAN_W-3:0], 1'b0};
                    exp_w = exp_w - WEXP_W'(1);
                end
                else
                begin
                    man_w = {sum34[MAN_W], sum34[MAN_W-2:0]};
                end
                if (req.opnd.exp == EXP_ZERO)
                begin
                    rsp_next.value.exp = EXP_ZERO;
                    rsp_next.value.man = '0;
                    rsp_next.zero      = 1'b1;
                end
                else if (exp_w > WEXP_W'($signed(EXP_MAX)))
                begin
                    // Exponent ran out: clamp to the largest single value
                    rsp_next.value.exp = EXP_MAX;
                    rsp_next.value.man = sgn ? EXT_NEG_MAX : SGL_POS_MAX;
                    rsp_next.ovf       = 1'b1;
                    rsp_next.neg       = sgn;
                end
                else if (exp_w < WEXP_W'(EXP_MIN))
                begin
                    // A left step from the smallest exponent would hit the zero code
                    rsp_next.value.exp = EXP_ZERO;
                    rsp_next.value.man = '0;
                    rsp_next.unf       = 1'b1;
                    rsp_next.zero      = 1'b1;
                end
                else
                begin
                    // Truncation after the add gives round-to-nearest
                    rsp_next.value.exp = exp_w[EXP_W-1:0];
                    rsp_next.value.man = man_w & SGL_MASK;
                    rsp_next.neg       = man_w[MAN_W-1];
                end
            end

            FCU_OP_FIX:
            begin
                exp_w   = WEXP_W'($signed(req.opnd.exp));
                fix33   = $signed({sgn, ~sgn, req.opnd.man[MAN_W-2:0]});
                fix_amt = WEXP_W'(FIX_SHIFT) - exp_w;
                // Very small exponents only leave the sign fill behind
                if (fix_amt > WEXP_W'(FIX_SH_CLAMP))
                    fix_amt = WEXP_W'(FIX_SH_CLAMP);
                fix_sh = fix33 >>> fix_amt[LEAD_W-1:0];
                rsp_next.value.exp = '0;
                if (req.opnd.exp == EXP_ZERO)
                begin
                    rsp_next.value.man = '0;
                    rsp_next.zero      = 1'b1;
                end
                else if (exp_w > WEXP_W'(FIX_EXP_MAX))
                begin
                    rsp_next.value.man = sgn ? INT_MIN : INT_MAX;
                    rsp_next.ovf       = 1'b1;
                    rsp_next.neg       = sgn;
                end
                else
                begin
                    rsp_next.value.man = fix_sh[MAN_W-1:0];
                    rsp_next.neg       = fix_sh[MAN_W-1];
                    rsp_next.zero      = (fix_sh[MAN_W-1:0] == '0);
                end
            end

            default:
            begin
                // Unknown code: no result is reported
                rsp_next.valid = 1'b0;
            end
        endcase
    end

    // Result register; every operation answers one edge after the request
    // Flags follow even with valid low, so the file must qualify them by valid
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            rsp_reg <= RSP_RESET;
        else
            rsp_reg <= rsp_next;
    end

    assign rsp = rsp_reg;

endmodule // fcu_unit

// file: fcu_unit_asserts.sv
`timescale 1ns/1ps

// Port checker for the conversion unit
module fcu_unit_asserts
    import fcu_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // Watched ports
    input wire fcu_req_type req,
    input wire fcu_rsp_type rsp
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // One-hot codes only; anything else is refused
    logic legal;
    assign legal = req.op inside {FCU_OP_NORM, FCU_OP_RND, FCU_OP_FIX, FCU_OP_FLOAT};

    // Request shapes; the zero code never counts as a large exponent
    sequence s_take(fcu_op_type o);
        req.valid && req.op == o;
    endsequence
    sequence s_fix_big;
        s_take(FCU_OP_FIX) ##0 (req.opnd.exp != EXP_ZERO && $signed(req.opnd.exp) > 30);
    endsequence

    a_answer_one_cycle: assert property (req.valid && legal |=> rsp.valid)
        else $error("no answer one cycle after a request");
    a_idle_no_answer: assert property (!req.valid |=> !rsp.valid)
        else $error("answer without a request");
    a_bad_op_zero: assert property (req.valid && !legal |=> rsp == RSP_RESET)
        else $error("illegal code not refused");
    a_fix_ovf_flag: assert property (s_fix_big |=> rsp.ovf)
        else $error("large exponent without overflow");
    a_fix_sat_pos: assert property (
        s_fix_big ##0 !req.opnd.man[31] |=> rsp.value.man == INT_MAX)
        else $error("positive overflow not saturated");
    a_fix_sat_neg: assert property (
        s_fix_big ##0 req.opnd.man[31] |=> rsp.value.man == INT_MIN)
        else $error("negative overflow not saturated");
    a_fix_unit_exp: assert property (
        s_take(FCU_OP_FIX) ##0 req.opnd.exp == 8'h00 |=>
        rsp.value.man == ($past(req.opnd.man[31]) ? 32'hFFFF_FFFE : 32'h0000_0001))
        else $error("exponent zero conversion wrong");
    a_float_zero_code: assert property (
        s_take(FCU_OP_FLOAT) ##0 req.opnd.man == 32'h0000_0000 |=>
        rsp.value == {EXP_ZERO, 32'h0000_0000} && rsp.zero)
        else $error("integer zero not the zero code");
    a_norm_one_shift: assert property (
        s_take(FCU_OP_NORM) ##0 req.opnd.exp == 8'h00 && req.opnd.man[31:30] == 2'b01 |=>
        rsp.value == {8'hFF, 1'b0, $past(req.opnd.man[29:0]), 1'b0})
        else $error("single shift normalize wrong");
    a_neg_sign_bit: assert property (rsp.neg == rsp.value.man[31])
        else $error("negative flag disagrees with the sign bit");
    a_unf_zero_code: assert property (
        rsp.unf |-> rsp.zero && rsp.value == {EXP_ZERO, 32'h0000_0000})
        else $error("underflow without the zero code");
endmodule // fcu_unit_asserts

bind fcu_unit fcu_unit_asserts u_fcu_unit_asserts (.mclk(mclk), .reset_n(reset_n),
    .req(req), .rsp(rsp));

// file: fcu_decode_model.sv
`timescale 1ns/1ps

// Decode stage model: issues one request word per edge
module fcu_decode_model
    import fcu_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Instruction from the bench
    input  wire fcu_req_type cmd,
    // Request toward the unit
    output fcu_req_type      req
);
    // Idle operand inverted so a stale word is never mistaken for live data
    always_ff @(posedge mclk)
        req <= cmd.valid ? cmd : '{1'b0, cmd.op, ~cmd.opnd};
endmodule // fcu_decode_model

// file: float_conversion_unit_tb.sv
`timescale 1ns/1ps

module float_conversion_unit_tb
    import fcu_pkg::*;
;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    fcu_req_type cmd = '0;
    fcu_req_type req;
    fcu_rsp_type rsp;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    // Core clock, 10 ns period
    always #5 mclk = ~mclk;

    fcu_decode_model u_fcu_decode_model (.mclk(mclk), .cmd(cmd), .req(req));
    fcu_unit u_fcu_unit (.mclk(mclk), .reset_n(reset_n), .req(req), .rsp(rsp));

    // Verdict and end of run
    task automatic complete_run;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare valid and value, count and report
    task automatic check(input logic [40:0] got, input logic [40:0] want);
        tests_run++;
        if (got !== want)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    // One request through decode; the answer lands two edges later
    task automatic xfer(input fcu_op_type op, input logic [7:0] e, input logic [31:0] m,
                        input logic [39:0] want);
        @(posedge mclk) cmd <= '{1'b1, op, '{e, m}};
        @(posedge mclk) cmd.valid <= 1'b0;
        @(posedge mclk);
        #1 check({rsp.valid, rsp.value}, {1'b1, want});
    endtask

    // Leading counts, both signs, flush and zero input
    task automatic t_norm;
        xfer(FCU_OP_NORM, 8'h00, 32'h0000_1000, {8'hED, 32'h0000_0000});
        xfer(FCU_OP_NORM, 8'h00, 32'hFFFF_F000, {8'hEC, 32'h8000_0000});
        xfer(FCU_OP_NORM, 8'h05, 32'h4000_0000, {8'h04, 32'h0000_0000});
        xfer(FCU_OP_NORM, 8'h00, 32'h6000_0001, {8'hFF, 32'h4000_0002});
        xfer(FCU_OP_NORM, 8'h00, 32'hFFFF_FFFF, {8'hE0, 32'h8000_0000});
        xfer(FCU_OP_NORM, 8'h81, 32'h0000_0001, {8'h80, 32'h0000_0000});
        xfer(FCU_OP_NORM, 8'h10, 32'h0000_0000, {8'h80, 32'h0000_0000});
    endtask

    // Half-unit add, carry out and saturation
    task automatic t_rnd;
        xfer(FCU_OP_RND, 8'h00, 32'h0000_0080, {8'h00, 32'h0000_0100});
        xfer(FCU_OP_RND, 8'h00, 32'h0000_007F, {8'h00, 32'h0000_0000});
        xfer(FCU_OP_RND, 8'h00, 32'h7FFF_FF80, {8'h01, 32'h0000_0000});
        xfer(FCU_OP_RND, 8'h7F, 32'h7FFF_FF80, {8'h7F, 32'h7FFF_FF00});
        xfer(FCU_OP_RND, 8'h00, 32'hFFFF_FF80, {8'hFF, 32'h8000_0000});
        xfer(FCU_OP_RND, 8'h81, 32'hFFFF_FF80, {8'h80, 32'h0000_0000});
        xfer(FCU_OP_RND, 8'h80, 32'h1234_5678, {8'h80, 32'h0000_0000});
    endtask

    // Range edge, saturation and floor rounding
    task automatic t_fix;
        xfer(FCU_OP_FIX, 8'h01, 32'h4000_0000, {8'h00, 32'h0000_0003});
        xfer(FCU_OP_FIX, 8'h1E, 32'h7FFF_FFFF, {8'h00, 32'h7FFF_FFFF});
        xfer(FCU_OP_FIX, 8'h1F, 32'h0000_0000, {8'h00, INT_MAX});
        xfer(FCU_OP_FIX, 8'h1F, 32'h8000_0000, {8'h00, INT_MIN});
        xfer(FCU_OP_FIX, 8'hFF, 32'h0000_0000, {8'h00, 32'h0000_0000});
        xfer(FCU_OP_FIX, 8'hFF, 32'h8000_0000, {8'h00, 32'hFFFF_FFFF});
        xfer(FCU_OP_FIX, 8'h00, 32'h8000_0000, {8'h00, 32'hFFFF_FFFE});
    endtask

    // Most negative integer, plus and minus one, and zero
    task automatic t_float;
        xfer(FCU_OP_FLOAT, 8'h5A, 32'h0000_0000, {8'h80, 32'h0000_0000});
        xfer(FCU_OP_FLOAT, 8'h00, 32'h0000_0001, {8'h00, 32'h0000_0000});
        xfer(FCU_OP_FLOAT, 8'h00, 32'hFFFF_FFFF, {8'hFF, 32'h8000_0000});
        xfer(FCU_OP_FLOAT, 8'h00, 32'h8000_0000, {8'h1E, 32'h8000_0000});
    endtask

    // Two-hot code must give an empty answer
    task automatic t_refuse;
        @(posedge mclk) cmd <= '{1'b1, fcu_op_type'(4'b0011), '{8'h01, 32'h4000_0000}};
        @(posedge mclk) cmd.valid <= 1'b0;
        @(posedge mclk);
        #1 check({rsp.valid, rsp.value}, 41'h0);
    endtask

    // Requests on consecutive edges, then idle
    task automatic t_back_to_back;
        @(posedge mclk) cmd <= '{1'b1, FCU_OP_FIX, '{8'h01, 32'h4000_0000}};
        @(posedge mclk) cmd <= '{1'b1, FCU_OP_FLOAT, '{8'h00, 32'h0000_0002}};
        @(posedge mclk) cmd.valid <= 1'b0;
        #1 check({rsp.valid, rsp.value}, {1'b1, 8'h00, 32'h0000_0003});
        @(posedge mclk);
        #1 check({rsp.valid, rsp.value}, {1'b1, 8'h01, 32'h0000_0000});
        @(posedge mclk);
        #1 check({40'h0, rsp.valid}, 41'h0);
    endtask

    // Cycle ceiling against a hung run
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            errors++;
            complete_run();
        end
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_norm();
        t_rnd();
        t_fix();
        t_float();
        t_refuse();
        t_back_to_back();
        complete_run();
    end
endmodule // float_conversion_unit_tb
